// >>> design/egbifm_top.sv
// Purpose: interrupt flag and enable registers of event group b
// Assumes: register port strobes are one cycle, never both at once
// Notes: read data valid only in the cycle after the read strobe
//   irq outputs lag a flag or enable change by one registered stage
//   an event in the cycle of its own clearing write keeps the flag set
//   unmapped reads still answer, with zero, so software never stalls
// What this block does
// - flag reads one while event latched
// - reserved bits read zero, writes ignored
// - flags a low byte layout
// - flags b holds timer 4 events
// - flags c holds capture 4-6 events
// - enable a covers timer 3, compares, fault
// - fault enable resets to one
// - enable b covers timer 4 sources
// - enable c covers capture sources
// - all flags reset to zero
// - other enables reset to zero
// - flags a upper holds timer 3 bits
//
// The plain strobed port is this design's own decision.
`timescale 1ns/1ps
module egbifm_top
	import egbifm_pkg::*;
(
	input wire logic sys_clk,
	input wire logic resetn,
	input wire logic [15:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire egbifm_events_type events,
	output logic [15:0] reg_rdata_q,
	output logic reg_rvalid_q,
	output egbifm_irq_type irq_group_q,
	output logic irq_q
);

	egbifm_req_type req;

	// one select per register word, from an exact address compare
	logic sel_flags_a;
	logic sel_flags_b;
	logic sel_flags_c;
	logic sel_enable_a;
	logic sel_enable_b;
	logic sel_enable_c;

	// decoded strobes
	logic wr_flags_a;
	logic wr_flags_b;
	logic wr_flags_c;
	logic wr_enable_a;
	logic wr_enable_b;
	logic wr_enable_c;
	logic hit;

	// event vectors in register layout
	logic [15:0] set_a;
	logic [3:0] set_b;
	logic [2:0] set_c;

	// register contents
	logic [15:0] flags_a;
	logic [3:0] flags_b;
	logic [2:0] flags_c;
	logic [15:0] enable_a;
	logic [3:0] enable_b;
	logic [2:0] enable_c;

	// full-width register words, reserved positions held at zero
	logic [15:0] view_flags_a;
	logic [15:0] view_flags_b;
	logic [15:0] view_flags_c;
	logic [15:0] view_enable_a;
	logic [15:0] view_enable_b;
	logic [15:0] view_enable_c;

	// write data trimmed to each register's width
	logic [15:0] wdata_a;
	logic [3:0] wdata_b;
	logic [2:0] wdata_c;

	// per-source request: flag and its enable both set
	egbifm_events_type pend;

	// read path and request levels
	logic [15:0] rdata_d;
	logic rvalid_d;
	egbifm_irq_type irq_group_d;
	logic irq_d;

	// bundle the port into one request
	always_comb begin
		req.addr = reg_addr;
		req.wdata = reg_wdata;
		req.wr = reg_wr;
		req.rd = reg_rd;
	end

	// exact compare per word; neighbouring addresses never alias
	always_comb begin
		sel_flags_a = (req.addr == OFS_FLAGS_A);
		sel_flags_b = (req.addr == OFS_FLAGS_B);
		sel_flags_c = (req.addr == OFS_FLAGS_C);
		sel_enable_a = (req.addr == OFS_ENABLE_A);
		sel_enable_b = (req.addr == OFS_ENABLE_B);
		sel_enable_c = (req.addr == OFS_ENABLE_C);
	end

	// a write reaches only the word it names; unmapped writes vanish
	always_comb begin
		wr_flags_a = req.wr && sel_flags_a;
		wr_flags_b = req.wr && sel_flags_b;
		wr_flags_c = req.wr && sel_flags_c;
		wr_enable_a = req.wr && sel_enable_a;
		wr_enable_b = req.wr && sel_enable_b;
		wr_enable_c = req.wr && sel_enable_c;
	end

	// any mapped word; a miss still answers the read
	always_comb begin
		hit = sel_flags_a || sel_flags_b || sel_flags_c ||
			sel_enable_a || sel_enable_b || sel_enable_c;
	end

	// write data cut to each register; reserved bits dropped here
	always_comb begin
		wdata_a = req.wdata & IMPL_A;
		wdata_b = req.wdata[3:0];
		wdata_c = req.wdata[2:0];
	end

	// place each event pulse at its flag position
	always_comb begin
		set_a = 16'h0000;
		set_a[BIT_A_T3_OVF] = events.timer3_overflow_event;
		set_a[BIT_A_T3_UNF] = events.timer3_underflow_event;
		set_a[BIT_A_T3_CMP] = events.timer3_compare_event;
		set_a[BIT_A_T3_PER] = events.timer3_period_event;
		set_a[BIT_A_CMP6] = events.compare6_event;
		set_a[BIT_A_CMP5] = events.compare5_event;
		set_a[BIT_A_CMP4] = events.compare4_event;
		set_a[BIT_A_PDRV] = events.power_drive_fault_event;
	end

	// timer 4 pulses into flags b positions
	always_comb begin
		set_b = 4'h0;
		set_b[BIT_B_T4_OVF] = events.timer4_overflow_event;
		set_b[BIT_B_T4_UNF] = events.timer4_underflow_event;
		set_b[BIT_B_T4_CMP] = events.timer4_compare_event;
		set_b[BIT_B_T4_PER] = events.timer4_period_event;
	end

	// capture pulses into flags c positions
	always_comb begin
		set_c = 3'h0;
		set_c[BIT_C_CAP6] = events.capture6_event;
		set_c[BIT_C_CAP5] = events.capture5_event;
		set_c[BIT_C_CAP4] = events.capture4_event;
	end

	// sticky flag registers, one instance per register
	egbifm_flag_reg #(
		.WIDTH(16),
		.IMPL(IMPL_A)
	) u_flags_a (
		.sys_clk(sys_clk),
		.resetn(resetn),
		.set(set_a),
		.clr_we(wr_flags_a),
		.clr_data(wdata_a),
		.flags_q(flags_a)
	);

	egbifm_flag_reg #(
		.WIDTH(4),
		.IMPL(IMPL_B)
	) u_flags_b (
		.sys_clk(sys_clk),
		.resetn(resetn),
		.set(set_b),
		.clr_we(wr_flags_b),
		.clr_data(wdata_b),
		.flags_q(flags_b)
	);

	egbifm_flag_reg #(
		.WIDTH(3),
		.IMPL(IMPL_C)
	) u_flags_c (
		.sys_clk(sys_clk),
		.resetn(resetn),
		.set(set_c),
		.clr_we(wr_flags_c),
		.clr_data(wdata_c),
		.flags_q(flags_c)
	);

	// enable registers; only enable a has a bit that resets to one
	egbifm_enable_reg #(
		.WIDTH(16),
		.IMPL(IMPL_A),
		.RST(RST_ENABLE_A)
	) u_enable_a (
		.sys_clk(sys_clk),
		.resetn(resetn),
		.we(wr_enable_a),
		.wdata(wdata_a),
		.enable_q(enable_a)
	);

	egbifm_enable_reg #(
		.WIDTH(4),
		.IMPL(IMPL_B),
		.RST(RST_ENABLE_B)
	) u_enable_b (
		.sys_clk(sys_clk),
		.resetn(resetn),
		.we(wr_enable_b),
		.wdata(wdata_b),
		.enable_q(enable_b)
	);

	egbifm_enable_reg #(
		.WIDTH(3),
		.IMPL(IMPL_C),
		.RST(RST_ENABLE_C)
	) u_enable_c (
		.sys_clk(sys_clk),
		.resetn(resetn),
		.we(wr_enable_c),
		.wdata(wdata_c),
		.enable_q(enable_c)
	);

	// register words as software sees them
	always_comb begin
		view_flags_a = flags_a & IMPL_A;
		view_flags_b = {12'h000, flags_b} & IMPL_B;
		view_flags_c = {13'h0, flags_c} & IMPL_C;
		view_enable_a = enable_a & IMPL_A;
		view_enable_b = {12'h000, enable_b} & IMPL_B;
		view_enable_c = {13'h0, enable_c} & IMPL_C;
	end

	// per-source request; a flag alone never asks for service
	always_comb begin
		pend.timer3_overflow_event = flags_a[BIT_A_T3_OVF] & enable_a[BIT_A_T3_OVF];
		pend.timer3_underflow_event = flags_a[BIT_A_T3_UNF] & enable_a[BIT_A_T3_UNF];
		pend.timer3_compare_event = flags_a[BIT_A_T3_CMP] & enable_a[BIT_A_T3_CMP];
		pend.timer3_period_event = flags_a[BIT_A_T3_PER] & enable_a[BIT_A_T3_PER];
		pend.compare6_event = flags_a[BIT_A_CMP6] & enable_a[BIT_A_CMP6];
		pend.compare5_event = flags_a[BIT_A_CMP5] & enable_a[BIT_A_CMP5];
		pend.compare4_event = flags_a[BIT_A_CMP4] & enable_a[BIT_A_CMP4];
		pend.power_drive_fault_event = flags_a[BIT_A_PDRV] & enable_a[BIT_A_PDRV];
		pend.timer4_overflow_event = flags_b[BIT_B_T4_OVF] & enable_b[BIT_B_T4_OVF];
		pend.timer4_underflow_event = flags_b[BIT_B_T4_UNF] & enable_b[BIT_B_T4_UNF];
		pend.timer4_compare_event = flags_b[BIT_B_T4_CMP] & enable_b[BIT_B_T4_CMP];
		pend.timer4_period_event = flags_b[BIT_B_T4_PER] & enable_b[BIT_B_T4_PER];
		pend.capture6_event = flags_c[BIT_C_CAP6] & enable_c[BIT_C_CAP6];
		pend.capture5_event = flags_c[BIT_C_CAP5] & enable_c[BIT_C_CAP5];
		pend.capture4_event = flags_c[BIT_C_CAP4] & enable_c[BIT_C_CAP4];
	end

	// every read strobe answers, mapped or not, so software never stalls
	always_comb begin
		rvalid_d = req.rd;
	end

	// read mux; narrow registers zero-extend, misses read zero
	always_comb begin
		rdata_d = 16'h0000;
		if (req.rd && hit) begin
			case (req.addr)
				OFS_FLAGS_A: begin
					rdata_d = view_flags_a;
				end
				OFS_FLAGS_B: begin
					rdata_d = view_flags_b;
				end
				OFS_FLAGS_C: begin
					rdata_d = view_flags_c;
				end
				OFS_ENABLE_A: begin
					rdata_d = view_enable_a;
				end
				OFS_ENABLE_B: begin
					rdata_d = view_enable_b;
				end
				OFS_ENABLE_C: begin
					rdata_d = view_enable_c;
				end
				default: begin
					rdata_d = 16'h0000;
				end
			endcase
		end
	end

	// data stands for exactly one cycle after the strobe
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			reg_rdata_q <= RST_RDATA;
			reg_rvalid_q <= 1'b0;
		end else begin
			reg_rdata_q <= rdata_d;
			reg_rvalid_q <= rvalid_d;
		end
	end

	// request levels follow flag and enable together, not the raw event
	always_comb begin
		irq_group_d.group_a = pend.timer3_overflow_event | pend.timer3_underflow_event |
			pend.timer3_compare_event | pend.timer3_period_event |
			pend.compare6_event | pend.compare5_event | pend.compare4_event |
			pend.power_drive_fault_event;
		irq_group_d.group_b = pend.timer4_overflow_event | pend.timer4_underflow_event |
			pend.timer4_compare_event | pend.timer4_period_event;
		irq_group_d.group_c = pend.capture6_event | pend.capture5_event |
			pend.capture4_event;
	end

	// one line for the processor, raised by any pending source
	always_comb begin
		irq_d = |pend;
	end

	// registered so outputs are glitch free; costs one cycle of latency
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			irq_group_q <= '0;
			irq_q <= 1'b0;
		end else begin
			irq_group_q <= irq_group_d;
			irq_q <= irq_d;
		end
	end

endmodule : egbifm_top

// >>> design/egbifm_pkg.sv
// Purpose: shared constants and carriers for the group b interrupt flag/enable block
// Assumes: 16-bit word-addressed register port, one clock, active-low async reset
// Notes: offsets are word addresses as seen on the register port
package egbifm_pkg;

	localparam int ADDR_W = 16;
	localparam int DATA_W = 16;

	// register word addresses
	localparam logic [15:0] OFS_ENABLE_A = 16'h752c;
	localparam logic [15:0] OFS_ENABLE_B = 16'h752d;
	localparam logic [15:0] OFS_ENABLE_C = 16'h752e;
	localparam logic [15:0] OFS_FLAGS_A = 16'h752f;
	localparam logic [15:0] OFS_FLAGS_B = 16'h7530;
	localparam logic [15:0] OFS_FLAGS_C = 16'h7531;

	// register a bit positions (flags and enables share the layout)
	localparam int BIT_A_T3_OVF = 10;
	localparam int BIT_A_T3_UNF = 9;
	localparam int BIT_A_T3_CMP = 8;
	localparam int BIT_A_T3_PER = 7;
	localparam int BIT_A_CMP6 = 3;
	localparam int BIT_A_CMP5 = 2;
	localparam int BIT_A_CMP4 = 1;
	localparam int BIT_A_PDRV = 0;

	// register b bit positions
	localparam int BIT_B_T4_OVF = 3;
	localparam int BIT_B_T4_UNF = 2;
	localparam int BIT_B_T4_CMP = 1;
	localparam int BIT_B_T4_PER = 0;

	// register c bit positions
	localparam int BIT_C_CAP6 = 2;
	localparam int BIT_C_CAP5 = 1;
	localparam int BIT_C_CAP4 = 0;

	// implemented bits; everything else is reserved and reads zero
	localparam logic [15:0] IMPL_A = 16'h078f;
	localparam logic [15:0] IMPL_B = 16'h000f;
	localparam logic [15:0] IMPL_C = 16'h0007;

	// values after reset
	localparam logic [15:0] RST_FLAGS = 16'h0000;
	localparam logic [15:0] RST_ENABLE_A = 16'h0001;
	localparam logic [15:0] RST_ENABLE_B = 16'h0000;
	localparam logic [15:0] RST_ENABLE_C = 16'h0000;
	localparam logic [15:0] RST_RDATA = 16'h0000;

	// one-cycle event pulses from the timer, compare, capture and fault units
	typedef struct packed {
		logic timer3_overflow_event;
		logic timer3_underflow_event;
		logic timer3_compare_event;
		logic timer3_period_event;
		logic compare6_event;
		logic compare5_event;
		logic compare4_event;
		logic power_drive_fault_event;
		logic timer4_overflow_event;
		logic timer4_underflow_event;
		logic timer4_compare_event;
		logic timer4_period_event;
		logic capture6_event;
		logic capture5_event;
		logic capture4_event;
	} egbifm_events_type;

	// one register port request
	typedef struct packed {
		logic [15:0] addr;
		logic [15:0] wdata;
		logic wr;
		logic rd;
	} egbifm_req_type;

	// per-group interrupt request levels
	typedef struct packed {
		logic group_a;
		logic group_b;
		logic group_c;
	} egbifm_irq_type;

endpackage : egbifm_pkg

// >>> design/egbifm_flag_reg.sv
// Purpose: one sticky flag register, set by hardware, cleared by writing ones
// Assumes: set pulses and write strobe are synchronous to sys_clk
// Notes: reserved bits are held at zero and ignore both sets and clears
`timescale 1ns/1ps
module egbifm_flag_reg
	import egbifm_pkg::*;
#(
	parameter int WIDTH = 16,
	parameter logic [15:0] IMPL = 16'hffff
) (
	input wire logic sys_clk,
	input wire logic resetn,
	input wire logic [WIDTH-1:0] set,
	input wire logic clr_we,
	input wire logic [WIDTH-1:0] clr_data,
	output logic [WIDTH-1:0] flags_q
);

	logic [WIDTH-1:0] flags_d;
	logic [WIDTH-1:0] clr_mask;

	// clear first, then set, so an event in the clearing cycle survives
	always_comb begin
		clr_mask = clr_we ? (clr_data & IMPL[WIDTH-1:0]) : '0;
		flags_d = (flags_q & ~clr_mask) | (set & IMPL[WIDTH-1:0]);
		flags_d = flags_d & IMPL[WIDTH-1:0];
	end

	// flags come out of reset cleared
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			flags_q <= RST_FLAGS[WIDTH-1:0];
		end else begin
			flags_q <= flags_d;
		end
	end

endmodule : egbifm_flag_reg

// >>> design/egbifm_enable_reg.sv
// Purpose: one read/write enable register with a per-bit reset value
// Assumes: write strobe synchronous to sys_clk
// Notes: reserved bits never store a written one
`timescale 1ns/1ps
module egbifm_enable_reg
	import egbifm_pkg::*;
#(
	parameter int WIDTH = 16,
	parameter logic [15:0] IMPL = 16'hffff,
	parameter logic [15:0] RST = 16'h0000
) (
	input wire logic sys_clk,
	input wire logic resetn,
	input wire logic we,
	input wire logic [WIDTH-1:0] wdata,
	output logic [WIDTH-1:0] enable_q
);

	logic [WIDTH-1:0] enable_d;

	// plain store, reserved bits masked off
	always_comb begin
		enable_d = we ? (wdata & IMPL[WIDTH-1:0]) : enable_q;
	end

	// reset value differs per register (fault enable starts on)
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			enable_q <= RST[WIDTH-1:0] & IMPL[WIDTH-1:0];
		end else begin
			enable_q <= enable_d;
		end
	end

endmodule : egbifm_enable_reg

// >>> sim/egbifm_checker.sv
// Purpose: port-level checks for the group b flag/enable block
// Assumes: one clock domain, active-low async reset
// Notes: irq figures count the extra registered stage
`timescale 1ns/1ps
module egbifm_checker
	import egbifm_pkg::*;
(
	input wire logic sys_clk,
	input wire logic resetn,
	input wire logic [15:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire egbifm_events_type events,
	input wire logic [15:0] reg_rdata_q,
	input wire logic reg_rvalid_q,
	input wire egbifm_irq_type irq_group_q,
	input wire logic irq_q
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!resetn);
	logic [15:0] msk;
	// implemented bits of the addressed word; unmapped gives none
	assign msk = (reg_addr == OFS_ENABLE_A || reg_addr == OFS_FLAGS_A) ? IMPL_A :
		(reg_addr == OFS_ENABLE_B || reg_addr == OFS_FLAGS_B) ? IMPL_B :
		(reg_addr == OFS_ENABLE_C || reg_addr == OFS_FLAGS_C) ? IMPL_C : 16'h0000;
	// event, then a read of flags a in the next cycle
	sequence s_fault_rd;
		events.power_drive_fault_event ##1 (reg_rd && reg_addr == OFS_FLAGS_A);
	endsequence
	sequence s_t3per_rd;
		events.timer3_period_event ##1 (reg_rd && reg_addr == OFS_FLAGS_A);
	endsequence
	a_rvalid_follows_rd: assert property (reg_rd |=> reg_rvalid_q)
		else $error("read strobe gave no valid");
	a_rdata_one_cycle: assert property (!reg_rd |=> !reg_rvalid_q && reg_rdata_q == 16'h0000)
		else $error("read data stood too long");
	a_resv_bits_zero: assert property (reg_rd |=> (reg_rdata_q & ~$past(msk)) == 16'h0000)
		else $error("reserved bit read as one");
	a_irq_is_or: assert property (irq_q == (|irq_group_q))
		else $error("irq differs from group or");
	a_irq_rise_cause: assert property ($rose(irq_q) |-> ($past(events, 2) != '0) || $past(reg_wr, 2))
		else $error("irq rose with no event or write");
	a_irq_fall_cause: assert property ($fell(irq_q) |-> $past(reg_wr, 2))
		else $error("irq fell with no write");
	a_fault_flag_read: assert property (s_fault_rd |=> reg_rdata_q[BIT_A_PDRV])
		else $error("fault flag not latched");
	a_t3per_flag_read: assert property (s_t3per_rd |=> reg_rdata_q[BIT_A_T3_PER])
		else $error("timer 3 period flag not latched");
endmodule : egbifm_checker

bind egbifm_top egbifm_checker i_chk (.sys_clk, .resetn, .reg_addr, .reg_wdata, .reg_wr,
	.reg_rd, .events, .reg_rdata_q, .reg_rvalid_q, .irq_group_q, .irq_q);

// >>> sim/egbifm_top_test.sv
// Purpose: self-checking bench for the group b flag/enable block
// Assumes: reads answered one cycle later, irq two cycles after cause
// Notes: read results go through a queue of expected words
`timescale 1ns/1ps
module egbifm_top_test
	import egbifm_pkg::*;
;
	logic sys_clk, resetn, reg_wr, reg_rd, reg_rvalid_q, irq_q;
	logic [15:0] reg_addr, reg_wdata, reg_rdata_q;
	egbifm_events_type events;
	egbifm_irq_type irq_group_q;
	int n_errors, checks, cyc;
	integer seed;
	logic [15:0] exp_q[$];
	logic [15:0] fl[3], en[3];

	egbifm_top i_dut (.sys_clk, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .events,
		.reg_rdata_q, .reg_rvalid_q, .irq_group_q, .irq_q);

	initial begin
		sys_clk = 1'b0;
		forever #12.5 sys_clk = ~sys_clk;
	end

	// every input set once per edge, so back-to-back calls never clash
	task acc(input logic w, input logic r, input logic [15:0] a, input logic [15:0] d,
		input logic [14:0] e);
		reg_wr <= w;
		reg_rd <= r;
		reg_addr <= a;
		reg_wdata <= d;
		events <= egbifm_events_type'(e);
		@(posedge sys_clk);
	endtask : acc

	task rd(input logic [15:0] a, input logic [15:0] x);
		exp_q.push_back(x);
		acc(1'b0, 1'b1, a, 16'h0000, 15'h0000);
	endtask : rd

	task cmp(input logic [15:0] g, input logic [15:0] x);
		checks++;
		if (g !== x) begin
			n_errors++;
			$display("[FAIL] %0t got %h want %h", $time, g, x);
		end
	endtask : cmp

	// two idle edges cover flag then irq register stage
	task chk_irq;
		logic [2:0] x;
		x = {|(fl[0] & en[0]), |(fl[1] & en[1]), |(fl[2] & en[2])};
		acc(1'b0, 1'b0, 16'h0000, 16'h0000, 15'h0000);
		acc(1'b0, 1'b0, 16'h0000, 16'h0000, 15'h0000);
		@(negedge sys_clk);
		cmp({13'h0000, irq_group_q}, {13'h0000, x});
		cmp({15'h0000, irq_q}, {15'h0000, |x});
		@(posedge sys_clk);
	endtask : chk_irq

	// event vector bits to their flag positions in word j
	function automatic logic [15:0] fmap(input logic [15:0] j, input logic [14:0] e);
		if (j == 16'h0000)
			return {5'h00, e[14:11], 3'h0, e[10:7]};
		if (j == 16'h0001)
			return {12'h000, e[6:3]};
		return {13'h0000, e[2:0]};
	endfunction : fmap

	task results;
		$display("errors %0d checks %0d", n_errors, checks);
		if (n_errors == 0 && checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : results

	// sampled mid-cycle, clear of the launching edge
	always @(negedge sys_clk) begin
		if (reg_rvalid_q === 1'b1) begin
			if (exp_q.size() == 0) begin
				n_errors++;
				$display("[FAIL] %0t unexpected read data", $time);
			end else
				cmp(reg_rdata_q, exp_q.pop_front());
		end
	end

	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 3000) begin
			n_errors++;
			results;
		end
	end

	initial begin
		logic [15:0] k, q, c, m;
		logic [31:0] e;
		logic [15:0] im[3];
		im = '{IMPL_A, IMPL_B, IMPL_C};
		seed = 32'h8631;
		resetn = 1'b0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 16'h0000;
		reg_wdata = 16'h0000;
		events = '0;
		fl = '{default: 16'h0000};
		en = '{RST_ENABLE_A, RST_ENABLE_B, RST_ENABLE_C};
		repeat (12) @(posedge sys_clk);
		resetn <= 1'b1;
		// reset values straight after release
		for (k = 0; k < 3; k++) begin
			rd(OFS_ENABLE_A + k, en[k]);
			rd(OFS_FLAGS_A + k, 16'h0000);
		end
		// fault source works with no setup
		acc(1'b0, 1'b0, 16'h0000, 16'h0000, 15'h0080);
		fl[0] = 16'h0001;
		chk_irq;
		acc(1'b1, 1'b0, OFS_FLAGS_A, 16'h0001, 15'h0000);
		fl[0] = 16'h0000;
		chk_irq;
		// all ones into enables, reserved bits must drop
		for (k = 0; k < 3; k++) begin
			acc(1'b1, 1'b0, OFS_ENABLE_A + k, 16'hffff, 15'h0000);
			en[k] = im[k];
			rd(OFS_ENABLE_A + k, im[k]);
		end
		acc(1'b1, 1'b0, 16'h752b, 16'hffff, 15'h0000);
		rd(16'h752b, 16'h0000);
		rd(16'h7532, 16'h0000);
		// each source alone lands on its own flag bit
		for (int i = 0; i < 15; i++) begin
			e = 32'h1 << i;
			acc(1'b0, 1'b0, 16'h0000, 16'h0000, e[14:0]);
			for (q = 0; q < 3; q++)
				rd(OFS_FLAGS_A + q, fmap(q, e[14:0]));
			for (q = 0; q < 3; q++)
				acc(1'b1, 1'b0, OFS_FLAGS_A + q, 16'hffff, 15'h0000);
		end
		// random events racing random clears, random masks
		for (int i = 0; i < 12; i++) begin
			k = 16'(i % 3);
			e = $random(seed);
			c = 16'($random(seed));
			m = 16'($random(seed));
			acc(1'b1, 1'b0, OFS_FLAGS_A + k, c, e[14:0]);
			fl[k] = fl[k] & ~c;
			for (q = 0; q < 3; q++)
				fl[q] = fl[q] | fmap(q, e[14:0]);
			for (q = 0; q < 3; q++)
				rd(OFS_FLAGS_A + q, fl[q]);
			acc(1'b1, 1'b0, OFS_ENABLE_A + k, m, 15'h0000);
			en[k] = m & im[k];
			rd(OFS_ENABLE_A + k, en[k]);
			chk_irq;
		end
		// reset in mid-run brings every register back to its reset value
		resetn <= 1'b0;
		repeat (3) @(posedge sys_clk);
		resetn <= 1'b1;
		fl = '{default: 16'h0000};
		en = '{RST_ENABLE_A, RST_ENABLE_B, RST_ENABLE_C};
		for (k = 0; k < 3; k++) begin
			rd(OFS_ENABLE_A + k, en[k]);
			rd(OFS_FLAGS_A + k, 16'h0000);
		end
		// event and its own clear in one cycle: the set wins, no irq while disabled
		acc(1'b1, 1'b0, OFS_FLAGS_C, 16'h0007, 15'h0001);
		fl[2] = 16'h0001;
		rd(OFS_FLAGS_C, 16'h0001);
		chk_irq;
		// every read asked for must have been answered
		if (exp_q.size() != 0) begin
			n_errors++;
			$display("[FAIL] %0t %0d reads never answered", $time, exp_q.size());
		end
		results;
	end
endmodule : egbifm_top_test
